/* File: eitrg_top.sv */
// Interval trigger top: APB registers, position counters, trigger compare.
// Assumes A/B encoder pins asynchronous to REF_CLK (20 MHz).
// Notes on behaviour
// - Counting steps per period are interpolation factor times edge factor for edges at least ipf_val clocks apart.
// - Interpolation selectable as 1, 2, 4, 5, 10, 20, 25, 50 or 100.
// - Edge evaluation selectable as 1, 2 or 4.
// - One scaling setting drives both trigger and auxiliary counters.
// - Modes are off, single position and periodic.
// - Single mode gives exactly one pulse when position hits start.
// - Periodic mode pulses at start and then every interval steps.
// - Start select picks programmed start or position at apply time.
//
// Local design decisions: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module eitrg_top (
    input  wire logic        REF_CLK,
    input  wire logic        RSTN,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic        ENC_A,
    input  wire logic        ENC_B,
    input  wire logic        AUX_A,
    input  wire logic        AUX_B,
    output logic             TRIG_OUT
);
    eitrg_scale_if sc_main ();
    eitrg_scale_if sc_aux ();

    // Synchronisers, counters, staged settings and run state
    logic [1:0]              a_sync_r;
    logic [1:0]              b_sync_r;
    logic [1:0]              xa_sync_r;
    logic [1:0]              xb_sync_r;
    logic [31:0]             pos_r;
    logic [31:0]             aux_pos_r;
    logic [31:0]             next_r;
    logic [31:0]             startpos_r;
    logic [31:0]             interval_r;
    logic [31:0]             run_int_r;
    logic [5:0]              scale_r;
    logic [4:0]              cfg_r;
    logic                    reject_r;
    logic [1:0]              run_mode_r;
    eitrg_pkg::eitrg_state_t state_r;
    eitrg_pkg::eitrg_state_t state_nxt;

    // Two-flop synchronisers for the encoder pins
    // Only the second stage is read; the first may go metastable
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            a_sync_r  <= 2'h0;
            b_sync_r  <= 2'h0;
            xa_sync_r <= 2'h0;
            xb_sync_r <= 2'h0;
        end else begin
            a_sync_r  <= {a_sync_r[0], ENC_A};
            b_sync_r  <= {b_sync_r[0], ENC_B};
            xa_sync_r <= {xa_sync_r[0], AUX_A};
            xb_sync_r <= {xb_sync_r[0], AUX_B};
        end
    end

    // Shared scaling feeds both counter paths
    assign sc_main.ipf      = scale_r[3:0];
    assign sc_main.edge_sel = scale_r[5:4];
    assign sc_aux.ipf       = scale_r[3:0];
    assign sc_aux.edge_sel  = scale_r[5:4];

    eitrg_step_gen u_main (
        .clk   (REF_CLK),
        .rst_n (RSTN),
        .a_s   (a_sync_r[1]),
        .b_s   (b_sync_r[1]),
        .sc    (sc_main)
    );
    eitrg_step_gen u_aux (
        .clk   (REF_CLK),
        .rst_n (RSTN),
        .a_s   (xa_sync_r[1]),
        .b_s   (xb_sync_r[1]),
        .sc    (sc_aux)
    );

    // APB decode; slave always ready, unmapped reads zero with error
    // Writes to read-only words are dropped without an error
    wire acc      = PSEL & PENABLE;
    wire wr       = acc & PWRITE;
    wire wr_scale = wr & (PADDR == eitrg_pkg::OFS_SCALE);
    wire wr_cfg   = wr & (PADDR == eitrg_pkg::OFS_TRIG_CFG);
    wire wr_start = wr & (PADDR == eitrg_pkg::OFS_STARTPOS);
    wire wr_int   = wr & (PADDR == eitrg_pkg::OFS_INTERVAL);
    wire wr_apply = wr & (PADDR == eitrg_pkg::OFS_APPLY) & PWDATA[0];
    wire mapped   = (PADDR[1:0] == 2'h0) && (PADDR <= eitrg_pkg::OFS_NEXT_POS);

    // Validity checks on the written codes and staged interval
    wire [3:0] w_ipf   = PWDATA[eitrg_pkg::SCALE_IPF_LSB +: 4];
    wire [1:0] w_edge  = PWDATA[eitrg_pkg::SCALE_EDGE_LSB +: 2];
    wire scale_ok = (w_ipf <= eitrg_pkg::INTERP_X100) &&
                    (w_edge <= eitrg_pkg::EDGE_EVAL_X4);
    wire [1:0] c_mode  = cfg_r[eitrg_pkg::CFG_MODE_LSB +: 2];
    wire c_start = cfg_r[eitrg_pkg::CFG_START_BIT];
    wire cfg_ok = (c_mode <= eitrg_pkg::TRIG_MODE_PERIODIC) &&
                  ((c_mode != eitrg_pkg::TRIG_MODE_PERIODIC) ||
                   (interval_r >= eitrg_pkg::MIN_INTERVAL));

    assign PREADY  = 1'b1;
    assign PSLVERR = acc & (~mapped | (wr_scale & ~scale_ok) |
                     (wr_apply & ~cfg_ok));

    // Read mux
    always_comb begin
        PRDATA = eitrg_pkg::RST_ZERO;
        case (PADDR)
            eitrg_pkg::OFS_SCALE:    PRDATA = {26'h0, scale_r};
            eitrg_pkg::OFS_TRIG_CFG: PRDATA = {27'h0, cfg_r};
            eitrg_pkg::OFS_STARTPOS: PRDATA = startpos_r;
            eitrg_pkg::OFS_INTERVAL: PRDATA = interval_r;
            eitrg_pkg::OFS_STATUS:   PRDATA = {30'h0,
                                      (state_r == eitrg_pkg::ST_ARMED),
                                      reject_r};
            eitrg_pkg::OFS_POSITION: PRDATA = pos_r;
            eitrg_pkg::OFS_AUX_POS:  PRDATA = aux_pos_r;
            eitrg_pkg::OFS_NEXT_POS: PRDATA = next_r;
            default:                 PRDATA = eitrg_pkg::RST_ZERO;
        endcase
    end

    // Staged settings; a rejected write leaves the old value
    // Trigger settings wait for apply, so a half-written setup is never used; scale_r acts at once
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            scale_r    <= 6'h00;
            cfg_r      <= 5'h00;
            startpos_r <= eitrg_pkg::RST_ZERO;
            interval_r <= eitrg_pkg::RST_ZERO;
            reject_r   <= 1'b0;
        end else begin
            if (wr_scale && scale_ok) scale_r <= PWDATA[5:0];
            if (wr_cfg) cfg_r <= PWDATA[4:0];
            if (wr_start) startpos_r <= PWDATA;
            if (wr_int) interval_r <= PWDATA;
            if (wr_scale || wr_apply)
                reject_r <= wr_scale ? ~scale_ok : ~cfg_ok;
        end
    end

    // Main position counter; steps arrive already scaled
    wire [31:0] pos_step = sc_main.dir_up ? pos_r + 32'h1 : pos_r - 32'h1;
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            pos_r <= eitrg_pkg::RST_ZERO;
        end else if (sc_main.step) begin
            pos_r <= pos_step;
        end
    end

    // Auxiliary counter at the same scaling, kept for readback only
    wire [31:0] aux_step = sc_aux.dir_up ? aux_pos_r + 32'h1
                                         : aux_pos_r - 32'h1;
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            aux_pos_r <= eitrg_pkg::RST_ZERO;
        end else if (sc_aux.step) begin
            aux_pos_r <= aux_step;
        end
    end

    // Trigger compare on the live count, so the pulse is combinational
    wire do_apply = wr_apply & cfg_ok;

    // Start point of a run; the current position fires on the next cycle
    // An apply landing on a hit cycle may thus give a second pulse at once
    wire [31:0] start_pt = (c_start == eitrg_pkg::START_FROM_CURRENT_POS) ?
                           pos_r : startpos_r;
    wire hit      = (state_r == eitrg_pkg::ST_ARMED) && (pos_r == next_r);
    assign TRIG_OUT = hit;

    // Run state; an accepted apply overrides whatever the hit did
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            eitrg_pkg::ST_IDLE:  state_nxt = state_r;
            eitrg_pkg::ST_ARMED:
                if (hit && run_mode_r == eitrg_pkg::TRIG_MODE_SINGLE_POS)
                    state_nxt = eitrg_pkg::ST_DONE;
            eitrg_pkg::ST_DONE:  state_nxt = state_r;
            default:             state_nxt = eitrg_pkg::ST_IDLE;
        endcase
        if (do_apply)
            state_nxt = (c_mode == eitrg_pkg::TRIG_MODE_OFF) ?
                        eitrg_pkg::ST_IDLE : eitrg_pkg::ST_ARMED;
    end

    // Start point and next compare value
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            state_r    <= eitrg_pkg::ST_IDLE;
            next_r     <= eitrg_pkg::RST_ZERO;
            run_int_r  <= eitrg_pkg::RST_ZERO;
            run_mode_r <= eitrg_pkg::TRIG_MODE_OFF;
        end else begin
            state_r <= state_nxt;
            if (do_apply) begin
                run_mode_r <= c_mode;
                run_int_r  <= interval_r;
                next_r     <= start_pt;
            end else if (hit &&
                         run_mode_r == eitrg_pkg::TRIG_MODE_PERIODIC) begin
                next_r <= next_r + run_int_r;
            end
        end
    end
endmodule
`default_nettype wire

/* File: eitrg_pkg.sv */
// Package for the encoder interval trigger: register map, codes, constants.
// Assumes an APB slave with 32-bit data and word-aligned registers.
package eitrg_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_SCALE    = 8'h00;
    localparam logic [7:0] OFS_TRIG_CFG = 8'h04;
    localparam logic [7:0] OFS_STARTPOS = 8'h08;
    localparam logic [7:0] OFS_INTERVAL = 8'h0C;
    localparam logic [7:0] OFS_APPLY    = 8'h10;
    localparam logic [7:0] OFS_STATUS   = 8'h14;
    localparam logic [7:0] OFS_POSITION = 8'h18;
    localparam logic [7:0] OFS_AUX_POS  = 8'h1C;
    localparam logic [7:0] OFS_NEXT_POS = 8'h20;

    // Field positions
    localparam int SCALE_IPF_LSB  = 0;   // 4 bits
    localparam int SCALE_EDGE_LSB = 4;   // 2 bits
    localparam int CFG_MODE_LSB   = 0;   // 2 bits
    localparam int CFG_START_BIT  = 4;
    localparam int ST_REJECT_BIT  = 0;
    localparam int ST_ARMED_BIT   = 1;

    // Interpolation factor codes
    localparam logic [3:0] INTERP_X1   = 4'h0;
    localparam logic [3:0] INTERP_X2   = 4'h1;
    localparam logic [3:0] INTERP_X4   = 4'h2;
    localparam logic [3:0] INTERP_X5   = 4'h3;
    localparam logic [3:0] INTERP_X10  = 4'h4;
    localparam logic [3:0] INTERP_X20  = 4'h5;
    localparam logic [3:0] INTERP_X25  = 4'h6;
    localparam logic [3:0] INTERP_X50  = 4'h7;
    localparam logic [3:0] INTERP_X100 = 4'h8;

    // Edge evaluation codes
    localparam logic [1:0] EDGE_EVAL_X1 = 2'h0;
    localparam logic [1:0] EDGE_EVAL_X2 = 2'h1;
    localparam logic [1:0] EDGE_EVAL_X4 = 2'h2;

    // Trigger modes
    localparam logic [1:0] TRIG_MODE_OFF        = 2'h0;
    localparam logic [1:0] TRIG_MODE_SINGLE_POS = 2'h1;
    localparam logic [1:0] TRIG_MODE_PERIODIC   = 2'h2;

    // Start select
    localparam logic START_FROM_CURRENT_POS    = 1'b0;
    localparam logic START_FROM_PROGRAMMED_POS = 1'b1;

    // Minimum periodic interval in counting steps
    localparam logic [31:0] MIN_INTERVAL = 32'h0000_0006;

    // Reset values
    localparam logic [31:0] RST_ZERO = 32'h0000_0000;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b001,
        ST_ARMED  = 3'b010,
        ST_DONE   = 3'b100
    } eitrg_state_t;
endpackage

/* File: eitrg_scale_if.sv */
// Interface carrying the shared scaling setting and count steps.
// Assumes one clock domain; the counter module only reads the setting.
`timescale 1ns/1ps
`default_nettype none
interface eitrg_scale_if;
    logic [3:0] ipf;        // Interpolation code
    logic [1:0] edge_sel;   // Edge evaluation code
    logic       step;       // One counting step
    logic       dir_up;     // Direction of step
    modport ctrl (output ipf, output edge_sel, input step, input dir_up);
    modport cnt  (input ipf, input edge_sel, output step, output dir_up);
endinterface
`default_nettype wire

/* File: eitrg_step_gen.sv */
// Quadrature decoder and interpolation divider producing counting steps.
// Assumes A/B already synchronised; setting is shared by both counters.
`timescale 1ns/1ps
`default_nettype none
module eitrg_step_gen (
    input  wire logic    clk,
    input  wire logic    rst_n,
    input  wire logic    a_s,
    input  wire logic    b_s,
    eitrg_scale_if.cnt   sc
);
    logic [1:0] ab_r;
    logic [6:0] rem_r;
    logic [6:0] rem_nxt;
    logic [6:0] ipf_val;
    logic       edge_a_rise;
    logic       any_edge;
    logic       edge_ok;
    logic       up;
    logic       rem_busy;

    // Interpolation factor table; each qualified edge is spread into
    // ipf_val counting steps, one per clock, as the pins carry no
    // analog phase to interpolate
    assign ipf_val = (sc.ipf == eitrg_pkg::INTERP_X2)   ? 7'h02 :
                     (sc.ipf == eitrg_pkg::INTERP_X4)   ? 7'h04 :
                     (sc.ipf == eitrg_pkg::INTERP_X5)   ? 7'h05 :
                     (sc.ipf == eitrg_pkg::INTERP_X10)  ? 7'h0A :
                     (sc.ipf == eitrg_pkg::INTERP_X20)  ? 7'h14 :
                     (sc.ipf == eitrg_pkg::INTERP_X25)  ? 7'h19 :
                     (sc.ipf == eitrg_pkg::INTERP_X50)  ? 7'h32 :
                     (sc.ipf == eitrg_pkg::INTERP_X100) ? 7'h64 : 7'h01;

    // Edge qualification by multiplier 1, 2 or 4; A leading B counts up
    assign any_edge    = (ab_r != {a_s, b_s});
    assign edge_a_rise = a_s & ~ab_r[1];
    assign up          = a_s ^ ab_r[0];
    assign edge_ok     = (sc.edge_sel == eitrg_pkg::EDGE_EVAL_X4) ? any_edge :
                         (sc.edge_sel == eitrg_pkg::EDGE_EVAL_X2) ?
                             (ab_r[1] != a_s) : edge_a_rise;
    // A new edge restarts the burst, so edges closer than ipf_val clocks
    // lose the rest of the previous burst
    assign rem_busy    = (rem_r != 7'h00);
    assign rem_nxt     = edge_ok  ? ipf_val - 7'h01 :
                         rem_busy ? rem_r - 7'h01 : rem_r;

    // Steps per period = interpolation x edge multiplier for edges at least ipf_val clocks apart
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ab_r      <= 2'h0;
            rem_r     <= 7'h00;
            sc.step   <= 1'b0;
            sc.dir_up <= 1'b1;
        end else begin
            ab_r    <= {a_s, b_s};
            rem_r   <= rem_nxt;
            sc.step <= edge_ok | rem_busy;
            if (edge_ok) begin
                sc.dir_up <= up;
            end
        end
    end
endmodule
`default_nettype wire

/* File: eitrg_trig_sva.sv */
// Checker for the interval trigger top; sees only its ports.
// Assumes a zero-wait APB slave and a single clock domain.
`timescale 1ns/1ps
`default_nettype none
module eitrg_trig_sva (
    input wire logic        REF_CLK,
    input wire logic        RSTN,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [7:0]  PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    input wire logic        TRIG_OUT
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RSTN);
    // Access phase decode shared by the error checks
    wire acc = PSEL && PENABLE;
    wire scl = acc && PWRITE && PADDR == eitrg_pkg::OFS_SCALE;
    a_ready_no_wait: assert property (acc |-> PREADY)
        else $error("Slave stretched an access");
    a_trig_one_cycle: assert property (TRIG_OUT |=> !TRIG_OUT)
        else $error("Trigger longer than one cycle");
    a_reset_no_trig: assert property (
        $rose(RSTN) |-> !TRIG_OUT ##1 !TRIG_OUT)
        else $error("Trigger right after reset");
    a_unmapped_err: assert property (
        acc && !PWRITE && PADDR > 8'h20 |-> PSLVERR && PRDATA == 32'h0)
        else $error("Unmapped read not refused");
    a_unaligned_err: assert property (
        acc && PADDR[1:0] != 2'h0 |-> PSLVERR)
        else $error("Unaligned access not refused");
    a_ipf_reject: assert property (
        scl && PWDATA[3:0] > 4'h8 |-> PSLVERR)
        else $error("Bad interpolation code taken");
    a_edge_reject: assert property (
        scl && PWDATA[5:4] == 2'h3 |-> PSLVERR)
        else $error("Bad edge code taken");
    a_scale_accept: assert property (
        scl && PWDATA[3:0] <= 4'h8 && PWDATA[5:4] != 2'h3 &&
        PWDATA[31:6] == 26'h0 |-> !PSLVERR)
        else $error("Good scale code refused");
    a_err_in_access: assert property (PSLVERR |-> acc)
        else $error("Error outside access phase");
endmodule
bind eitrg_top eitrg_trig_sva i_eitrg_trig_sva (.REF_CLK(REF_CLK), .RSTN(RSTN),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .TRIG_OUT(TRIG_OUT));
`default_nettype wire

/* File: eitrg_enc_model.sv */
// Behavioural quadrature encoder driving one A/B pair, forward only.
// Assumes move() is called from one process at a time.
`timescale 1ns/1ps
`default_nettype none
module eitrg_enc_model (
    input  wire logic clk,
    output var logic  a,
    output var logic  b
);
    logic [1:0] phase_r;
    initial begin
        phase_r = 2'h0;
        a = 1'b0;
        b = 1'b0;
    end
    // A leads B; four clocks per edge so the input sync never misses one
    task automatic move(input int n);
        repeat (n) begin
            repeat (4) @(posedge clk);
            phase_r = phase_r + 2'h1;
            a <= phase_r[1] ^ phase_r[0];
            b <= phase_r[1];
        end
    endtask
endmodule
`default_nettype wire

/* File: tb_top.sv */
// Self-checking bench for the interval trigger top.
// Assumes the encoder models and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        REF_CLK, RSTN, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
    logic        ENC_A, ENC_B, AUX_A, AUX_B, TRIG_OUT;
    logic [7:0]  PADDR;
    logic [31:0] PWDATA, PRDATA, rnd;
    logic [5:0]  v;
    logic [32:0] exp_q[$];
    logic        msk_q[$];
    int          num_errors, samples_checked, trig_cnt, mark, seed;
    eitrg_top i_eitrg_top (.REF_CLK(REF_CLK), .RSTN(RSTN), .PSEL(PSEL),
        .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
        .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .ENC_A(ENC_A),
        .ENC_B(ENC_B), .AUX_A(AUX_A), .AUX_B(AUX_B), .TRIG_OUT(TRIG_OUT));
    eitrg_enc_model i_eitrg_enc_model (.clk(REF_CLK), .a(ENC_A), .b(ENC_B));
    eitrg_enc_model i_eitrg_enc_model_aux (.clk(REF_CLK), .a(AUX_A),
        .b(AUX_B));
    initial begin
        REF_CLK = 1'b0;
        forever #25 REF_CLK = ~REF_CLK;
    end
    task check(input logic [32:0] got, input logic [32:0] want);
        samples_checked++;
        if (got !== want) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask
    task wrap_up;
        $display("checks=%0d errors=%0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // One APB transfer; the note goes on the queue before the request
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
             input logic [32:0] e, input logic m);
        int n;
        exp_q.push_back(e);
        msk_q.push_back(m);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge REF_CLK);
        PENABLE <= 1'b1;
        n = 0;
        do begin
            @(posedge REF_CLK);
            n++;
        end while (PREADY !== 1'b1 && n < 20);
        if (PREADY !== 1'b1) begin
            num_errors++;
            wrap_up();
        end
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        @(posedge REF_CLK);
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d, input logic e);
        apb(1'b1, a, d, {e, 32'h0}, 1'b0);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] d, input logic e);
        apb(1'b0, a, 32'h0, {e, d}, 1'b1);
    endtask
    task arm(input logic [31:0] c, s, iv, input logic e);
        wr(eitrg_pkg::OFS_TRIG_CFG, c, 1'b0);
        wr(eitrg_pkg::OFS_STARTPOS, s, 1'b0);
        wr(eitrg_pkg::OFS_INTERVAL, iv, 1'b0);
        wr(eitrg_pkg::OFS_APPLY, 32'h0000_0001, e);
    endtask
    // Moves the main axis, lets the sync chain drain, counts pulses
    task pulses(input int steps, input int want);
        i_eitrg_enc_model.move(steps);
        repeat (10) @(posedge REF_CLK);
        check(33'(trig_cnt - mark), 33'(want));
    endtask
    // Watcher: takes the oldest note at each completed transfer
    always @(posedge REF_CLK) begin
        if (TRIG_OUT === 1'b1)
            trig_cnt++;
        if (PSEL && PENABLE && PREADY === 1'b1 && exp_q.size() > 0) begin
            if (msk_q.pop_front())
                check({PSLVERR, PRDATA}, exp_q.pop_front());
            else
                check({PSLVERR, 32'h0},
                      {exp_q.pop_front() & 33'h1_0000_0000});
        end
    end
    initial begin
        seed = 28;
        RSTN = 1'b0;
        PSEL = 1'b0;
        PENABLE = 1'b0;
        PWRITE = 1'b0;
        PADDR = 8'h00;
        PWDATA = 32'h0;
        repeat (8) @(posedge REF_CLK);
        RSTN <= 1'b1;
        @(posedge REF_CLK);
        rd(eitrg_pkg::OFS_STATUS, 32'h0, 1'b0);
        rd(eitrg_pkg::OFS_POSITION, 32'h0, 1'b0);
        $display("test reset done");
        for (int j = 0; j < 3; j++) begin
            for (int i = 0; i < 9; i++) begin
                v = {j[1:0], i[3:0]};
                wr(eitrg_pkg::OFS_SCALE, {26'h0, v}, 1'b0);
                rd(eitrg_pkg::OFS_SCALE, {26'h0, v}, 1'b0);
            end
        end
        wr(eitrg_pkg::OFS_SCALE, 32'h0000_0009, 1'b1);
        wr(eitrg_pkg::OFS_SCALE, 32'h0000_0030, 1'b1);
        rd(eitrg_pkg::OFS_SCALE, 32'h0000_0028, 1'b0);
        wr(eitrg_pkg::OFS_SCALE, 32'h0000_0020, 1'b0);
        rd(8'h24, 32'h0, 1'b1);
        wr(8'h02, 32'h0000_0001, 1'b1);
        rnd = $random(seed);
        wr(eitrg_pkg::OFS_STARTPOS, rnd, 1'b0);
        rd(eitrg_pkg::OFS_STARTPOS, rnd, 1'b0);
        $display("test scale done");
        mark = trig_cnt;
        arm(32'h0000_0012, 32'h0000_0004, 32'h0000_0006, 1'b0);
        pulses(20, 3);
        rd(eitrg_pkg::OFS_POSITION, 32'h0000_0014, 1'b0);
        i_eitrg_enc_model_aux.move(8);
        repeat (10) @(posedge REF_CLK);
        rd(eitrg_pkg::OFS_AUX_POS, 32'h0000_0008, 1'b0);
        arm(32'h0000_0012, 32'h0000_0004, 32'h0000_0005, 1'b1);
        rd(eitrg_pkg::OFS_STATUS, 32'h0000_0003, 1'b0);
        pulses(8, 5);
        $display("test periodic done");
        mark = trig_cnt;
        arm(32'h0000_0011, 32'h0000_0023, 32'h0000_0006, 1'b0);
        pulses(12, 1);
        mark = trig_cnt;
        arm(32'h0000_0002, 32'h0000_0000, 32'h0000_0006, 1'b0);
        pulses(12, 3);
        mark = trig_cnt;
        arm(32'h0000_0000, 32'h0000_0000, 32'h0000_0006, 1'b0);
        arm(32'h0000_0003, 32'h0000_0000, 32'h0000_0006, 1'b1);
        pulses(10, 0);
        rd(eitrg_pkg::OFS_POSITION, 32'h0000_003E, 1'b0);
        rd(eitrg_pkg::OFS_NEXT_POS, 32'h0000_0034, 1'b0);
        rd(eitrg_pkg::OFS_TRIG_CFG, 32'h0000_0003, 1'b0);
        rd(eitrg_pkg::OFS_INTERVAL, 32'h0000_0006, 1'b0);
        $display("test modes done");
        wr(eitrg_pkg::OFS_SCALE, 32'h0000_0021, 1'b0);
        i_eitrg_enc_model.move(4);
        repeat (10) @(posedge REF_CLK);
        rd(eitrg_pkg::OFS_POSITION, 32'h0000_0046, 1'b0);
        wr(eitrg_pkg::OFS_SCALE, 32'h0000_0001, 1'b0);
        i_eitrg_enc_model.move(4);
        repeat (10) @(posedge REF_CLK);
        rd(eitrg_pkg::OFS_POSITION, 32'h0000_0048, 1'b0);
        $display("test scaling done");
        wrap_up();
    end
endmodule
`default_nettype wire
